// ---- src/ustep_map.svh ----
// constants for the unipolar stepper translator: phase patterns and timing
// assumes inclusion by bare name from the translator and host module files
`ifndef USTEP_MAP_SVH
`define USTEP_MAP_SVH
`define USTEP_PH_A 4'h1
`define USTEP_PH_B 4'h2
`define USTEP_PH_C 4'h4
`define USTEP_PH_D 4'h8
`define USTEP_POS_RESET 3'h0
`define USTEP_POS_LAST 3'h7
`define USTEP_STEP_MIN_NS 500
`define USTEP_CLK_NS 100
`define USTEP_STEP_MIN_CYC ((`USTEP_STEP_MIN_NS + `USTEP_CLK_NS - 1) / `USTEP_CLK_NS)
`endif

// ---- src/ustep_pkg.sv ----
// types for the unipolar stepper translator
// assumes nothing beyond the map header
package ustep_pkg;
    typedef enum logic [3:0] {
        USTEP_FMT_TWO = 4'h1,
        USTEP_FMT_WAVE = 4'h2,
        USTEP_FMT_HALF = 4'h4,
        USTEP_FMT_INHIBIT = 4'h8
    } ustep_fmt_e;
endpackage

// ---- src/ustep_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module ustep_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- src/ustep_translator.sv ----
// sequencer of a four-phase unipolar stepper translator
// assumes host pins are asynchronous and srst_i stands in for power-on reset
`timescale 1ns/1ps
`default_nettype none
`include "ustep_map.svh"
module ustep_translator (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // host control pins
    input wire logic step_i,
    input wire logic dir_rev_i,
    input wire logic one_phase_i,
    input wire logic half_step_i,
    input wire logic out_dis_i,
    // thermal sensor flag
    input wire logic over_temp_i,
    // phase drives and status
    output logic [3:0] phase_o,
    output logic [2:0] position_o,
    output logic inhibit_o
);
    import ustep_pkg::*;

    typedef struct packed {
        logic step_prev;
        logic [2:0] pos;
        logic [3:0] pat;
        logic [3:0] phase;
        logic inhibit;
    } ustep_state_s;

    ustep_state_s st_q;
    ustep_state_s st_d;
    logic [5:0] pins_s;
    logic step_s;
    logic dir_s;
    logic one_s;
    logic half_s;
    logic dis_s;
    logic hot_s;
    logic adv;
    ustep_fmt_e fmt;

    // every pin crosses two flops before use
    ustep_sync #(.WIDTH(6)) u_sync (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .async_i({step_i, dir_rev_i, one_phase_i, half_step_i, out_dis_i, over_temp_i}),
        .sync_o(pins_s)
    );
    assign {step_s, dir_s, one_s, half_s, dis_s, hot_s} = pins_s;

    // format decode from the two selects
    function automatic ustep_fmt_e fmt_decode(input logic one, input logic half);
        if (one && half)
            return USTEP_FMT_INHIBIT;
        else if (one)
            return USTEP_FMT_WAVE;
        else if (half)
            return USTEP_FMT_HALF;
        else
            return USTEP_FMT_TWO;
    endfunction

    // pattern for an eight-position index; full-step formats use even slots
    function automatic logic [3:0] pattern(input ustep_fmt_e f, input logic [2:0] p);
        logic [3:0] single;
        logic [3:0] nxt;
        single = 4'h0;
        nxt = 4'h0;
        case (p[2:1])
            2'h0:
            begin
                single = `USTEP_PH_A;
                nxt = `USTEP_PH_B;
            end
            2'h1:
            begin
                single = `USTEP_PH_B;
                nxt = `USTEP_PH_C;
            end
            2'h2:
            begin
                single = `USTEP_PH_C;
                nxt = `USTEP_PH_D;
            end
            default:
            begin
                single = `USTEP_PH_D;
                nxt = `USTEP_PH_A;
            end
        endcase
        case (f)
            USTEP_FMT_WAVE: pattern = single;
            // two-phase slot k is the pair ending at k, so position zero shows DA
            USTEP_FMT_TWO: pattern = single | ((p[2:1] == 2'h0) ? `USTEP_PH_D
                                     : (single >> 1));
            default: pattern = p[0] ? (single | nxt) : single;
        endcase
    endfunction

    // falling edge of the synchronised step
    assign adv = st_q.step_prev && !step_s;
    assign fmt = fmt_decode(one_s, half_s);

    // next state
    always_comb
    begin
        st_d = st_q;
        st_d.step_prev = step_s;
        st_d.inhibit = (fmt == USTEP_FMT_INHIBIT);
        if (adv && fmt != USTEP_FMT_INHIBIT)
        begin
            if (fmt == USTEP_FMT_HALF)
                st_d.pos = dir_s ? st_q.pos - 3'h1 : st_q.pos + 3'h1;
            else
                st_d.pos = dir_s ? {st_q.pos[2:1] - 2'h1, 1'b0}
                                 : {st_q.pos[2:1] + 2'h1, 1'b0};
        end
        // sequencer pattern kept apart from blanking, so inhibit holds it
        if (fmt == USTEP_FMT_INHIBIT)
            st_d.pat = st_q.pat;
        else
            st_d.pat = pattern(fmt, st_d.pos);
        // blanking only gates the drive; the held pattern survives it
        if (dis_s || hot_s)
            st_d.phase = 4'h0;
        else
            st_d.phase = st_d.pat;
    end

    // state register; reset doubles as power-on reset
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            st_q.step_prev <= 1'b0;
            st_q.pos <= `USTEP_POS_RESET;
            st_q.pat <= `USTEP_PH_A;
            st_q.phase <= `USTEP_PH_A;
            st_q.inhibit <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    assign phase_o = st_q.phase;
    assign position_o = st_q.pos;
    assign inhibit_o = st_q.inhibit;

    // assertions
    a_off_when_disabled: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ($past(dis_s) && !$past(srst_i)) |-> phase_o == 4'h0)
        else $error("phases on while disabled");
    a_off_when_hot: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ($past(hot_s) && !$past(srst_i)) |-> phase_o == 4'h0)
        else $error("phases on while over temperature");
    a_wave_one_hot: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ($past(fmt) == USTEP_FMT_WAVE && phase_o != 4'h0 && !$past(srst_i)) |-> $onehot(phase_o))
        else $error("wave format not one-hot");
    a_two_pair: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ($past(fmt) == USTEP_FMT_TWO && phase_o != 4'h0 && !$past(srst_i)) |-> $countones(phase_o) == 2)
        else $error("two-phase format not a pair");
    a_inhibit_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fmt == USTEP_FMT_INHIBIT) |=> $stable(position_o))
        else $error("position moved under inhibit");
    a_no_step_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !adv |=> $stable(position_o))
        else $error("position moved without step edge");
    a_fwd_half: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && fmt == USTEP_FMT_HALF && !dir_s) |=> position_o == $past(position_o) + 3'h1)
        else $error("half step forward wrong");
    a_rev_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && fmt == USTEP_FMT_WAVE && dir_s) |=> position_o[2:1] == $past(position_o[2:1]) - 2'h1)
        else $error("reverse step wrong");
    a_edge_single: assert property (@(posedge core_clk_i) disable iff (srst_i)
        adv |=> !adv)
        else $error("advance pulse longer than a cycle");
    a_reset_pattern: assert property (@(posedge core_clk_i)
        srst_i |=> phase_o == `USTEP_PH_A && position_o == `USTEP_POS_RESET)
        else $error("reset pattern wrong");

    // format shape and flag checks against the decoded selects, and drive restore once unblanked
    a_half_shape: assert property (@(posedge core_clk_i) disable iff (srst_i)
        ($past(fmt) == USTEP_FMT_HALF && phase_o != 4'h0 && !$past(srst_i))
        |-> $countones(phase_o) == (position_o[0] ? 2 : 1))
        else $error("half step pattern shape wrong");
    a_inhibit_flag: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !$past(srst_i) |-> inhibit_o == ($past(fmt) == USTEP_FMT_INHIBIT))
        else $error("inhibit flag disagrees with selects");
    a_restore_on: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!$past(dis_s) && !$past(hot_s) && !$past(srst_i)) |-> phase_o != 4'h0)
        else $error("phases dark while enabled");
    // step order checks for the full-step formats
    a_fwd_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && fmt == USTEP_FMT_WAVE && !dir_s) |=> position_o[2:1] == $past(position_o[2:1]) + 2'h1)
        else $error("wave step forward wrong");
    a_fwd_two: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && fmt == USTEP_FMT_TWO && !dir_s) |=> position_o[2:1] == $past(position_o[2:1]) + 2'h1)
        else $error("two-phase step forward wrong");
    a_rev_two: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && fmt == USTEP_FMT_TWO && dir_s) |=> position_o[2:1] == $past(position_o[2:1]) - 2'h1)
        else $error("two-phase step reverse wrong");
    a_even_full: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (adv && (fmt == USTEP_FMT_WAVE || fmt == USTEP_FMT_TWO)) |=> !position_o[0])
        else $error("full step left an odd position");
    // the advance pulse must mirror the synchronised step falling
    a_edge_detect: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !$past(srst_i) |-> adv == $fell(step_s))
        else $error("advance pulse does not match step edge");
endmodule
`default_nettype wire

// ---- test/unipolar_stepper_translator_test.sv ----
// self-checking bench for the stepper translator
// assumes a 10 MHz clock and the host model beside it
`timescale 1ns/1ps
`default_nettype none
module unipolar_stepper_translator_test;
    logic core_clk, srst, out_dis, over_temp, step, dir_rev, one_ph, half;
    logic [3:0] phase;
    logic [2:0] pos;
    logic inh;
    int err_count = 0;
    int checks_done = 0;
    ustep_host ustep_host_i (.core_clk_i(core_clk), .step_o(step), .dir_rev_o(dir_rev),
        .one_phase_o(one_ph), .half_step_o(half));
    ustep_translator ustep_translator_i (.core_clk_i(core_clk), .srst_i(srst), .step_i(step),
        .dir_rev_i(dir_rev), .one_phase_i(one_ph), .half_step_i(half), .out_dis_i(out_dis),
        .over_temp_i(over_temp), .phase_o(phase), .position_o(pos), .inhibit_o(inh));
    // clock generation
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [3:0] g, input logic [3:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one step, then the pattern it must land on
    task automatic stp(input logic [3:0] e);
        ustep_host_i.pulse();
        chk(phase, e);
    endtask
    // thermal and disable both blank, then the pattern returns
    task automatic blank_test(input logic [3:0] e);
        @(posedge core_clk) #1 out_dis = 1'b1;
        repeat (4) @(posedge core_clk);
        chk(phase, 4'h0);
        #1 out_dis = 1'b0;
        over_temp = 1'b1;
        repeat (4) @(posedge core_clk);
        chk(phase, 4'h0);
        #1 over_temp = 1'b0;
        repeat (4) @(posedge core_clk);
        chk(phase, e);
    endtask
    task automatic summarize();
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles needed
    initial
    begin
        repeat (3000) @(posedge core_clk);
        err_count++;
        summarize();
    end
    // power-on pattern with two-phase selects: A and D on
    task automatic reset_test();
        srst = 1'b1;
        out_dis = 1'b0;
        over_temp = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge core_clk);
        chk(phase, 4'h9);
        chk({1'b0, pos}, 4'h0);
        chk({3'h0, inh}, 4'h0);
    endtask
    // two-phase forward: AB, BC, CD, DA
    task automatic two_phase_test();
        stp(4'h3);
        stp(4'h6);
        stp(4'hc);
        stp(4'h9);
    endtask
    // wave forward from position zero
    task automatic wave_test();
        ustep_host_i.set_mode(3'h2);
        chk(phase, 4'h1);
        stp(4'h2);
        stp(4'h4);
        stp(4'h8);
        stp(4'h1);
    endtask
    // wave reverse: D, C, B, A
    task automatic wave_rev_test();
        ustep_host_i.set_mode(3'h6);
        stp(4'h8);
        stp(4'h4);
        stp(4'h2);
        stp(4'h1);
    endtask
    // half step through all eight positions and the wrap
    task automatic half_test();
        ustep_host_i.set_mode(3'h1);
        stp(4'h3);
        stp(4'h2);
        stp(4'h6);
        stp(4'h4);
        stp(4'hc);
        stp(4'h8);
        stp(4'h9);
        stp(4'h1);
    endtask
    // two-phase reverse from position zero wraps to CD
    task automatic two_rev_test();
        ustep_host_i.set_mode(3'h4);
        stp(4'hc);
        chk({1'b0, pos}, 4'h6);
    endtask
    // inhibit ignores steps and its held pattern survives blanking
    task automatic inhibit_test();
        ustep_host_i.set_mode(3'h3);
        stp(4'hc);
        chk({3'h0, inh}, 4'h1);
        chk({1'b0, pos}, 4'h6);
        blank_test(4'hc);
    endtask
    // reset in mid-run with wave selects leaves A alone on
    task automatic mid_reset_test();
        ustep_host_i.set_mode(3'h2);
        chk(phase, 4'h8);
        @(posedge core_clk) #1 srst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        repeat (4) @(posedge core_clk);
        chk(phase, 4'h1);
        chk({1'b0, pos}, 4'h0);
        stp(4'h2);
    endtask
    initial
    begin
        reset_test();
        two_phase_test();
        wave_test();
        wave_rev_test();
        half_test();
        two_rev_test();
        blank_test(4'hc);
        inhibit_test();
        mid_reset_test();
        summarize();
    end
endmodule
`default_nettype wire

// ---- test/ustep_host.sv ----
// host controller model: drives step, direction and format pins
// assumes the translator samples its pins on core_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "ustep_map.svh"
module ustep_host (
    // clock
    input wire logic core_clk_i,
    // host pins
    output logic step_o,
    output logic dir_rev_o,
    output logic one_phase_o,
    output logic half_step_o
);
    // idle low so select changes never look like a step
    initial
    begin
        step_o = 1'b0;
        {dir_rev_o, one_phase_o, half_step_o} = 3'h0;
    end
    // one pulse, 500 ns high then 500 ns low; the fall advances
    task automatic pulse();
        @(posedge core_clk_i) #1 step_o = 1'b1;
        repeat (`USTEP_STEP_MIN_CYC) @(posedge core_clk_i);
        #1 step_o = 1'b0;
        repeat (`USTEP_STEP_MIN_CYC) @(posedge core_clk_i);
    endtask
    // {dir, one-phase, half-step}, changed only while step is low
    task automatic set_mode(input logic [2:0] m);
        @(posedge core_clk_i) #1 {dir_rev_o, one_phase_o, half_step_o} = m;
        repeat (4) @(posedge core_clk_i);
    endtask
endmodule
`default_nettype wire
